/* File: common/msg_xmit_pkg.sv */
// Constants shared by the message transmitter and its bit-rate clock.
// Assumes a single 125 MHz master clock with a synchronous reset.
package msg_xmit_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 8;
  localparam int CLK_HZ          = 125000000;
  localparam int READ_STROBE_NS  = 700;
  localparam int LOAD_STROBE_NS  = 100;
  localparam int PHASE_SLOT_NS   = 100;
  // Least times, rounded up to whole cycles
  localparam int READ_CYCLES     = (READ_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_CYCLES     = (LOAD_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOT_CYCLES     = (PHASE_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHASE_COUNT     = 8;

  // ----------------------------------------------------------------
  // Bit rates and word format
  // ----------------------------------------------------------------
  localparam int BAUD_110        = 110;
  localparam int BAUD_300        = 300;
  localparam int BAUD_1200       = 1200;
  localparam int BAUD_2400       = 2400;
  localparam int BAUD_9600       = 9600;
  localparam logic [2:0] RATE_RESET      = 3'h4;
  localparam logic [3:0] BIT_COUNT_FINAL = 4'hC;
  localparam int WORD_BITS       = 11;
  localparam logic [6:0] END_TEXT_CODE   = 7'h04;
  localparam logic [6:0] RETURN_CODE     = 7'h0D;

  // ----------------------------------------------------------------
  // Cursor
  // ----------------------------------------------------------------
  localparam logic [6:0] LAST_COLUMN = 7'h49;
  localparam logic [4:0] LAST_ROW    = 5'h1A;

  // ----------------------------------------------------------------
  // Registers (byte offsets) and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_STATUS  = 4'h4;
  localparam logic [3:0] OFS_CURSOR  = 4'h8;
  localparam logic [3:0] OFS_CHAR    = 4'hC;
  localparam int CTL_START    = 0;
  localparam int CTL_SEL_CR   = 1;
  localparam int CTL_RATE_LSB = 2;
  localparam int CUR_ROW_LSB  = 8;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_REQ    = 8'h02,
    ST_READ   = 8'h04,
    ST_STEP   = 8'h08,
    ST_LOAD   = 8'h10,
    ST_ARM    = 8'h20,
    ST_SHIFT  = 8'h40,
    ST_FINISH = 8'h80
  } xmit_state_t;

endpackage

/* File: src/bitrate_clock_gen.sv */
// Bit-rate tick generator: one-cycle enable per bit period.
// Assumes the divisors are given in master clock cycles.
`timescale 1ns/1ps
module bitrate_clock_gen #(
  parameter int DIV_110  = 1136363,
  parameter int DIV_300  = 416666,
  parameter int DIV_1200 = 104166,
  parameter int DIV_2400 = 52083,
  parameter int DIV_9600 = 13020
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic [2:0] rateSelect,
  output logic            tick
);
  import msg_xmit_pkg::*;

  logic [20:0] count_reg;
  logic [20:0] count_next;
  logic [20:0] limit;

  always_comb
  begin
    unique case (rateSelect)
      3'h0:    limit = 21'(DIV_110 - 1);
      3'h1:    limit = 21'(DIV_300 - 1);
      3'h2:    limit = 21'(DIV_1200 - 1);
      3'h3:    limit = 21'(DIV_2400 - 1);
      default: limit = 21'(DIV_9600 - 1);
    endcase
  end

  // Held at zero while stopped so each run starts a full period late
  always_comb
  begin
    tick       = 1'b0;
    count_next = count_reg;
    if (!run)
    begin
      count_next = '0;
    end
    else if (count_reg >= limit)
    begin
      count_next = '0;
      tick       = 1'b1;
    end
    else
    begin
      count_next = count_reg + 21'h1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

endmodule

/* File: src/terminal_message_transmitter.sv */
// Transmit sequencer: reads a message from display memory, sends it
// as 11-bit asynchronous words and steers the cursor.
// Assumes memory, refresh timing and cursor logic share mclk.
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module terminal_message_transmitter #(
  parameter int DIV_110  = msg_xmit_pkg::CLK_HZ / msg_xmit_pkg::BAUD_110,
  parameter int DIV_300  = msg_xmit_pkg::CLK_HZ / msg_xmit_pkg::BAUD_300,
  parameter int DIV_1200 = msg_xmit_pkg::CLK_HZ / msg_xmit_pkg::BAUD_1200,
  parameter int DIV_2400 = msg_xmit_pkg::CLK_HZ / msg_xmit_pkg::BAUD_2400,
  parameter int DIV_9600 = msg_xmit_pkg::CLK_HZ / msg_xmit_pkg::BAUD_9600
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [3:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWriteData,
  input  wire logic [3:0]  avsByteEnable,
  output logic [31:0]      avsReadData,
  output logic             avsWaitRequest,
  input  wire logic        refreshRow,
  input  wire logic        retraceGate,
  input  wire logic [6:0]  memChar,
  input  wire logic        foreground_flag,
  input  wire logic        end_text_seen,
  input  wire logic        return_code_seen,
  output logic             readStrobe,
  output logic             column_increment_cmd,
  output logic             row_increment_cmd,
  output logic             column_clear_cmd,
  output logic             cursor_update_pulse,
  output logic [6:0]       cursor_column_counter,
  output logic [4:0]       cursor_row_counter,
  output logic             rollupRequest,
  output logic             keyboard_release,
  output logic             keyboardLocked,
  output logic             loadStrobe,
  output logic [7:0]       parallelData,
  output logic             serialOut
);
  import msg_xmit_pkg::*;

  // ----------------------------------------------------------------
  // Phase pulses
  // ----------------------------------------------------------------
  logic [3:0] slot_reg;
  logic [3:0] slot_next;
  logic [2:0] phase_reg;
  logic [2:0] phase_next;

  function automatic logic atPhase(input logic [2:0] idx, input logic [3:0] slot,
                                   input logic [2:0] ph);
    atPhase = (slot == 4'h0) && (ph == idx);
  endfunction

  always_comb
  begin
    slot_next  = slot_reg + 4'h1;
    phase_next = phase_reg;
    if (slot_reg == 4'(SLOT_CYCLES - 1))
    begin
      slot_next  = 4'h0;
      phase_next = phase_reg + 3'h1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      slot_reg  <= 4'h0;
      phase_reg <= 3'h0;
    end
    else
    begin
      slot_reg  <= slot_next;
      phase_reg <= phase_next;
    end
  end

  logic t00, t02, t03, t04, t05;
  assign t00 = atPhase(3'h0, slot_reg, phase_reg);
  assign t02 = atPhase(3'h2, slot_reg, phase_reg);
  assign t03 = atPhase(3'h3, slot_reg, phase_reg);
  assign t04 = atPhase(3'h4, slot_reg, phase_reg);
  assign t05 = atPhase(3'h5, slot_reg, phase_reg);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        selCr_reg;
  logic        selCr_next;
  logic [2:0]  rate_reg;
  logic [2:0]  rate_next;
  logic        startPulse;

  xmit_state_t state_reg;
  xmit_state_t state_next;
  logic        xmit_reg, xmit_next;
  logic        recv_reg, recv_next;
  logic        lock_reg, lock_next;
  logic        idle_gate_flop, idle_next;
  logic        eotCnt_reg, eotCnt_next;
  logic        shiftMode_reg, shiftMode_next;

  // Answer one cycle after the request appears
  assign avsWaitRequest = (avsRead | avsWrite) & ~ack_reg;
  assign avsReadData    = rdata_reg;

  always_comb
  begin
    ack_next   = (avsRead | avsWrite) & ~ack_reg;
    rdata_next = rdata_reg;
    selCr_next = selCr_reg;
    rate_next  = rate_reg;
    startPulse = 1'b0;
    if (avsRead & ~ack_reg)
    begin
      rdata_next = 32'h0;
      unique case (avsAddress)
        OFS_CONTROL: rdata_next = {27'h0, rate_reg, selCr_reg, 1'b0};
        OFS_STATUS:  rdata_next = {24'h0, 2'b00, shiftMode_reg, eotCnt_reg,
                                   idle_gate_flop, lock_reg, recv_reg, xmit_reg};
        OFS_CURSOR:  rdata_next = {19'h0, cursor_row_counter, 1'b0, cursor_column_counter};
        OFS_CHAR:    rdata_next = {24'h0, parallelData};
        default:     rdata_next = 32'h0;
      endcase
    end
    if (avsWrite & ack_reg & avsByteEnable[0] & (avsAddress == OFS_CONTROL))
    begin
      selCr_next = avsWriteData[CTL_SEL_CR];
      rate_next  = avsWriteData[CTL_RATE_LSB +: 3];
      startPulse = avsWriteData[CTL_START];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0;
      selCr_reg <= 1'b0;
      rate_reg  <= RATE_RESET;
    end
    else
    begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
      selCr_reg <= selCr_next;
      rate_reg  <= rate_next;
    end
  end

  // ----------------------------------------------------------------
  // Bit-rate clock
  // ----------------------------------------------------------------
  logic bitTick;

  bitrate_clock_gen #(
    .DIV_110  (DIV_110),
    .DIV_300  (DIV_300),
    .DIV_1200 (DIV_1200),
    .DIV_2400 (DIV_2400),
    .DIV_9600 (DIV_9600)
  ) u_rate (
    .mclk       (mclk),
    .reset      (reset),
    .run        (~idle_gate_flop),
    .rateSelect (rate_reg),
    .tick       (bitTick)
  );

  // ----------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------
  logic [6:0]  rrCnt_reg, rrCnt_next;
  logic [3:0]  ldCnt_reg, ldCnt_next;
  logic [3:0]  bitCnt_reg, bitCnt_next;
  logic [10:0] word_reg, word_next;
  logic [7:0]  char_reg, char_next;
  logic        fg_reg, fg_next, eot_reg, eot_next, cr_reg, cr_next;
  logic [6:0]  col_reg, col_next;
  logic [4:0]  row_reg, row_next;
  logic        serial_reg, serial_next;
  logic        colInc_next, rowInc_next, colClr_next, toggle_next;
  logic        colInc_reg, rowInc_reg, colClr_reg, toggle_reg;
  logic        rollup_next, rollup_reg, release_next, release_reg;
  logic        dataReq, window, bit_count_final;

  assign dataReq         = xmit_reg & idle_gate_flop;
  assign window          = ~refreshRow | retraceGate;
  assign bit_count_final = (bitCnt_reg == BIT_COUNT_FINAL);

  always_comb
  begin
    state_next     = state_reg;
    xmit_next      = xmit_reg;
    recv_next      = recv_reg;
    lock_next      = lock_reg;
    idle_next      = idle_gate_flop;
    eotCnt_next    = eotCnt_reg;
    shiftMode_next = shiftMode_reg;
    rrCnt_next     = rrCnt_reg;
    ldCnt_next     = ldCnt_reg;
    bitCnt_next    = bitCnt_reg;
    word_next      = word_reg;
    char_next      = char_reg;
    fg_next        = fg_reg;
    eot_next       = eot_reg;
    cr_next        = cr_reg;
    col_next       = col_reg;
    row_next       = row_reg;
    serial_next    = serial_reg;
    colInc_next    = 1'b0;
    rowInc_next    = 1'b0;
    colClr_next    = 1'b0;
    toggle_next    = 1'b0;
    rollup_next    = 1'b0;
    release_next   = 1'b0;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (startPulse)
        begin
          xmit_next  = 1'b1;
          recv_next  = 1'b0;
          lock_next  = 1'b1;
          state_next = ST_REQ;
        end
      end
      ST_REQ:
      begin
        if (dataReq & window & t04)
        begin
          rrCnt_next = 7'(READ_CYCLES);
          state_next = ST_READ;
        end
      end
      ST_READ:
      begin
        rrCnt_next = rrCnt_reg - 7'h1;
        if (rrCnt_reg == 7'h1)
        begin
          fg_next    = foreground_flag;
          eot_next   = end_text_seen;
          cr_next    = return_code_seen;
          state_next = ST_STEP;
          if (!end_text_seen)
            char_next = {foreground_flag, memChar};
          else if (selCr_reg)
            char_next = {1'b1, RETURN_CODE};
          else
            char_next = {1'b1, END_TEXT_CODE};
        end
      end
      ST_STEP:
      begin
        if (t02)
        begin
          toggle_next = 1'b1;
          if (eot_reg | cr_reg)
          begin
            rowInc_next = 1'b1;
            colClr_next = 1'b1;
            col_next    = 7'h0;
            if (row_reg != LAST_ROW)
              row_next = row_reg + 5'h1;
            rollup_next = eot_reg & (row_reg == LAST_ROW);
          end
          else
          begin
            colInc_next = 1'b1;
            col_next    = (col_reg == LAST_COLUMN) ? 7'h0 : col_reg + 7'h1;
          end
          if (fg_reg | eot_reg)
          begin
            ldCnt_next = 4'(LOAD_CYCLES - 1);
            idle_next  = 1'b0;
            state_next = ST_LOAD;
          end
          else
          begin
            state_next = ST_REQ;
          end
        end
      end
      ST_LOAD:
      begin
        if (t03 & eot_reg)
          eotCnt_next = 1'b1;
        if (ldCnt_reg != 4'h0)
          ldCnt_next = ldCnt_reg - 4'h1;
        else
          state_next = ST_ARM;
      end
      ST_ARM:
      begin
        if (t03 & eot_reg)
          eotCnt_next = 1'b1;
        if (t00)
        begin
          shiftMode_next = 1'b1;
          word_next      = {2'b11, char_reg, 1'b0};
          state_next     = ST_SHIFT;
        end
      end
      ST_SHIFT:
      begin
        if (bitTick & ~bit_count_final)
        begin
          serial_next = word_reg[0];
          word_next   = {1'b1, word_reg[10:1]};
          bitCnt_next = bitCnt_reg + 4'h1;
        end
        if (bit_count_final)
        begin
          serial_next = 1'b1;
          if (t00)
          begin
            idle_next      = 1'b1;
            bitCnt_next    = 4'h0;
            shiftMode_next = 1'b0;
            state_next     = eotCnt_reg ? ST_FINISH : ST_REQ;
          end
        end
      end
      ST_FINISH:
      begin
        if (t05 & dataReq)
        begin
          release_next = 1'b1;
          lock_next    = 1'b0;
          recv_next    = 1'b1;
          state_next   = ST_IDLE;
        end
      end
    endcase
    // Receive mode holds the end counter and transmit flag clear
    if (recv_next)
    begin
      eotCnt_next = 1'b0;
      xmit_next   = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_reg      <= ST_IDLE;
      xmit_reg       <= 1'b0;
      recv_reg       <= 1'b1;
      lock_reg       <= 1'b0;
      idle_gate_flop <= 1'b1;
      eotCnt_reg     <= 1'b0;
      shiftMode_reg  <= 1'b0;
      rrCnt_reg      <= 7'h0;
      ldCnt_reg      <= 4'h0;
      bitCnt_reg     <= 4'h0;
      word_reg       <= 11'h7FF;
      char_reg       <= 8'h00;
      fg_reg         <= 1'b0;
      eot_reg        <= 1'b0;
      cr_reg         <= 1'b0;
      col_reg        <= 7'h0;
      row_reg        <= 5'h0;
      serial_reg     <= 1'b1;
      colInc_reg     <= 1'b0;
      rowInc_reg     <= 1'b0;
      colClr_reg     <= 1'b0;
      toggle_reg     <= 1'b0;
      rollup_reg     <= 1'b0;
      release_reg    <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      xmit_reg       <= xmit_next;
      recv_reg       <= recv_next;
      lock_reg       <= lock_next;
      idle_gate_flop <= idle_next;
      eotCnt_reg     <= eotCnt_next;
      shiftMode_reg  <= shiftMode_next;
      rrCnt_reg      <= rrCnt_next;
      ldCnt_reg      <= ldCnt_next;
      bitCnt_reg     <= bitCnt_next;
      word_reg       <= word_next;
      char_reg       <= char_next;
      fg_reg         <= fg_next;
      eot_reg        <= eot_next;
      cr_reg         <= cr_next;
      col_reg        <= col_next;
      row_reg        <= row_next;
      serial_reg     <= serial_next;
      colInc_reg     <= colInc_next;
      rowInc_reg     <= rowInc_next;
      colClr_reg     <= colClr_next;
      toggle_reg     <= toggle_next;
      rollup_reg     <= rollup_next;
      release_reg    <= release_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign readStrobe            = state_reg == ST_READ;
  assign loadStrobe            = state_reg == ST_LOAD;
  assign column_increment_cmd  = colInc_reg;
  assign row_increment_cmd     = rowInc_reg;
  assign column_clear_cmd      = colClr_reg;
  assign cursor_update_pulse   = toggle_reg;
  assign cursor_column_counter = col_reg;
  assign cursor_row_counter    = row_reg;
  assign rollupRequest         = rollup_reg;
  assign keyboard_release      = release_reg;
  assign keyboardLocked        = lock_reg;
  // Flag bit is passed as is; parity substitution happens downstream
  assign parallelData          = char_reg;
  assign serialOut             = serial_reg;

endmodule

/* File: testbench/terminal_message_transmitter_props.sv */
// Checker for the message transmitter, watching top-level ports only.
// Assumes one mclk domain with a synchronous active-high reset.
`timescale 1ns/1ps
module terminal_message_transmitter_props (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       avsRead,
  input wire logic       avsWrite,
  input wire logic       avsWaitRequest,
  input wire logic       readStrobe,
  input wire logic       loadStrobe,
  input wire logic       serialOut,
  input wire logic       column_increment_cmd,
  input wire logic       row_increment_cmd,
  input wire logic       column_clear_cmd,
  input wire logic       cursor_update_pulse,
  input wire logic [4:0] cursor_row_counter,
  input wire logic       rollupRequest,
  input wire logic       keyboard_release,
  input wire logic       keyboardLocked,
  input wire logic [7:0] parallelData
);
  localparam int RD_LEN = 88;
  localparam int LD_LEN = 13;
  logic [7:0] rdLen_reg;
  logic [7:0] rdLen_next;
  logic [7:0] ldLen_reg;
  logic [7:0] ldLen_next;

  // ----------------------------------------------------------------
  // Strobe length counters
  // ----------------------------------------------------------------
  always_comb
  begin
    rdLen_next = readStrobe ? rdLen_reg + 8'h01 : 8'h00;
    ldLen_next = loadStrobe ? ldLen_reg + 8'h01 : 8'h00;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rdLen_reg <= 8'h00;
      ldLen_reg <= 8'h00;
    end
    else
    begin
      rdLen_reg <= rdLen_next;
      ldLen_reg <= ldLen_next;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_read_strobe_len: assert property ($fell(readStrobe) |-> rdLen_reg == 8'(RD_LEN))
    else $error("read strobe length wrong");
  a_load_strobe_len: assert property ($fell(loadStrobe) |-> ldLen_reg == 8'(LD_LEN))
    else $error("load strobe length wrong");
  a_fetch_when_idle: assert property ($rose(readStrobe) |-> !loadStrobe && serialOut && keyboardLocked)
    else $error("fetch while busy or unlocked");
  a_single_step: assert property (cursor_update_pulse |=> !cursor_update_pulse)
    else $error("cursor pulse too long");
  a_column_step: assert property (column_increment_cmd |-> cursor_update_pulse && !row_increment_cmd)
    else $error("column step without toggle");
  a_row_clear: assert property (row_increment_cmd |-> column_clear_cmd && cursor_update_pulse)
    else $error("row step without column clear");
  a_load_flag: assert property ($rose(loadStrobe) |-> parallelData[7])
    else $error("loaded word lacks flag bit");
  a_line_idle_load: assert property (loadStrobe |-> serialOut)
    else $error("line busy during load");
  a_release_unlock: assert property (keyboard_release |-> ##[0:1] !keyboardLocked)
    else $error("keyboard stays locked");
  a_rollup_last_row: assert property (rollupRequest |-> cursor_row_counter == 5'h1A)
    else $error("roll-up away from last row");
  a_bus_one_wait: assert property ($rose(avsRead || avsWrite) |-> avsWaitRequest ##1 !avsWaitRequest)
    else $error("bus wait cycle count wrong");

  c_rollup: cover property (rollupRequest);
  c_release: cover property (keyboard_release);
  c_load: cover property ($rose(loadStrobe));
endmodule

bind terminal_message_transmitter terminal_message_transmitter_props u_props (
  .mclk(mclk), .reset(reset), .avsRead(avsRead), .avsWrite(avsWrite), .avsWaitRequest(avsWaitRequest),
  .readStrobe(readStrobe), .loadStrobe(loadStrobe), .serialOut(serialOut),
  .column_increment_cmd(column_increment_cmd), .row_increment_cmd(row_increment_cmd),
  .column_clear_cmd(column_clear_cmd), .cursor_update_pulse(cursor_update_pulse),
  .cursor_row_counter(cursor_row_counter), .rollupRequest(rollupRequest),
  .keyboard_release(keyboard_release), .keyboardLocked(keyboardLocked), .parallelData(parallelData)
);

/* File: testbench/msg_memory_model.sv */
// Far side: display memory holding the message, scan timing, and a
// serial receiver standing in for the host.
// Assumes the bench fills msgQ and reads rxQ hierarchically.
`timescale 1ns/1ps
module msg_memory_model #(
  parameter int BIT_CYCLES = 20
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic readStrobe,
  input  wire logic serialOut,
  output logic [6:0] memChar,
  output logic       foreground_flag,
  output logic       end_text_seen,
  output logic       return_code_seen,
  output logic       refreshRow,
  output logic       retraceGate
);
  logic [9:0]  msgQ[$];
  logic [10:0] rxQ[$];
  logic [9:0]  curEntry = 10'h000;
  logic [9:0]  scanCnt = 10'h000;
  logic        strobeSeen = 1'b0;
  logic [10:0] word;

  // ----------------------------------------------------------------
  // Memory and scan timing
  // ----------------------------------------------------------------
  always @(posedge mclk)
  begin
    scanCnt <= reset ? 10'h000 : scanCnt + 10'h001;
    strobeSeen <= readStrobe;
    if (readStrobe && !strobeSeen && msgQ.size() > 0)
      curEntry <= msgQ.pop_front();
  end
  assign refreshRow = scanCnt[8];
  assign retraceGate = (scanCnt[5:0] < 6'h08);
  // Unselected memory shows inverted data so stale values cannot pass
  assign {foreground_flag, end_text_seen, return_code_seen, memChar} = readStrobe ? curEntry : ~curEntry;

  // ----------------------------------------------------------------
  // Serial receiver, mid-bit sampling
  // ----------------------------------------------------------------
  initial
  begin
    forever
    begin
      @(posedge mclk);
      if (!reset && serialOut === 1'b0)
      begin
        repeat (BIT_CYCLES / 2) @(posedge mclk);
        for (int i = 0; i < 11; i++)
        begin
          word[i] = serialOut;
          if (i < 10)
            repeat (BIT_CYCLES) @(posedge mclk);
        end
        rxQ.push_back(word);
      end
    end
  end
endmodule

/* File: testbench/terminal_message_transmitter_tb.sv */
// Self-checking bench: registers over Avalon-MM, two messages sent.
// Assumes shortened bit periods of 20 cycles for every rate.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module terminal_message_transmitter_tb;
  import msg_xmit_pkg::*;
  localparam int DIV = 20;
  logic mclk, reset, avsRead, avsWrite, avsWaitRequest, refreshRow, retraceGate;
  logic [3:0] avsAddress, avsByteEnable;
  logic [31:0] avsWriteData, avsReadData, rd;
  logic [6:0] memChar, cursor_column_counter;
  logic [4:0] cursor_row_counter;
  logic [7:0] parallelData;
  logic foreground_flag, end_text_seen, return_code_seen, readStrobe, column_increment_cmd, row_increment_cmd;
  logic column_clear_cmd, cursor_update_pulse, rollupRequest, keyboard_release, keyboardLocked, loadStrobe, serialOut;
  logic [10:0] expQ[$];
  int miscompares = 0;
  int cmpCount = 0;
  int rollups = 0;

  terminal_message_transmitter #(.DIV_110(DIV), .DIV_300(DIV), .DIV_1200(DIV), .DIV_2400(DIV), .DIV_9600(DIV)) dut (
    .mclk, .reset, .avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsByteEnable, .avsReadData, .avsWaitRequest,
    .refreshRow, .retraceGate, .memChar, .foreground_flag, .end_text_seen, .return_code_seen, .readStrobe,
    .column_increment_cmd, .row_increment_cmd, .column_clear_cmd, .cursor_update_pulse, .cursor_column_counter,
    .cursor_row_counter, .rollupRequest, .keyboard_release, .keyboardLocked, .loadStrobe, .parallelData, .serialOut);

  msg_memory_model #(.BIT_CYCLES(DIV)) mem (.mclk, .reset, .readStrobe, .serialOut, .memChar, .foreground_flag,
    .end_text_seen, .return_code_seen, .refreshRow, .retraceGate);

  // ----------------------------------------------------------------
  // Clock, watchdog, verdict
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk)
    if (rollupRequest === 1'b1)
      rollups++;

  task automatic endOfTest();
    if (miscompares == 0 && cmpCount > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (80000) @(posedge mclk);
    miscompares++;
    endOfTest();
  end

  // ----------------------------------------------------------------
  // Bus and message helpers
  // ----------------------------------------------------------------
  // Held until waitrequest is seen low; only the watchdog ends a hang
  task automatic avXfer(input logic wr, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rdv);
    avsAddress <= adr;
    avsWriteData <= wd;
    avsRead <= !wr;
    avsWrite <= wr;
    do @(posedge mclk); while (avsWaitRequest !== 1'b0);
    rdv = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic addChar(input logic [6:0] code, input logic fg, input logic eot, input logic cr, input logic sel);
    mem.msgQ.push_back({fg, eot, cr, code});
    if (eot)
      expQ.push_back({2'b11, 1'b1, (sel ? RETURN_CODE : END_TEXT_CODE), 1'b0});
    else if (fg)
      expQ.push_back({2'b11, 1'b1, code, 1'b0});
  endtask

  task automatic finishMessage();
    do @(posedge mclk); while (keyboard_release !== 1'b1);
    repeat (2 * DIV) @(posedge mclk);
    `CHK("word count", expQ.size(), mem.rxQ.size());
    for (int i = 0; i < expQ.size() && i < mem.rxQ.size(); i++)
      `CHK("serial word", expQ[i], mem.rxQ[i]);
    expQ.delete();
    mem.rxQ.delete();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    avsAddress = 4'h0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWriteData = 32'h00000000;
    avsByteEnable = 4'hF;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    avXfer(1'b0, OFS_STATUS, 32'h00000000, rd);
    `CHK("status reset", 32'h0000000A, rd);
    avXfer(1'b0, 4'h2, 32'h00000000, rd);
    `CHK("unmapped", 32'h00000000, rd);
    addChar(7'h41, 1'b1, 1'b0, 1'b0, 1'b0);
    addChar(7'h55, 1'b0, 1'b0, 1'b0, 1'b0);
    addChar(RETURN_CODE, 1'b1, 1'b0, 1'b1, 1'b0);
    addChar(7'h42, 1'b1, 1'b0, 1'b0, 1'b0);
    addChar(7'h7F, 1'b1, 1'b1, 1'b0, 1'b0);
    avXfer(1'b1, OFS_CONTROL, 32'h00000011, rd);
    `CHK("locked", 1'b1, keyboardLocked);
    finishMessage();
    avXfer(1'b0, OFS_CURSOR, 32'h00000000, rd);
    `CHK("cursor", 32'h00000200, rd);
    `CHK("column", 7'h00, cursor_column_counter);
    avXfer(1'b0, OFS_CHAR, 32'h00000000, rd);
    `CHK("end code", 32'h00000084, rd);
    avXfer(1'b0, OFS_STATUS, 32'h00000000, rd);
    `CHK("status end", 32'h0000000A, rd);
    // Second message ends on the last row and must roll up
    for (int i = 0; i < 24; i++)
      addChar(RETURN_CODE, 1'b1, 1'b0, 1'b1, 1'b1);
    addChar(7'h7F, 1'b1, 1'b1, 1'b0, 1'b1);
    avXfer(1'b1, OFS_CONTROL, 32'h00000003, rd);
    avXfer(1'b0, OFS_CONTROL, 32'h00000000, rd);
    `CHK("control", 32'h00000002, rd);
    finishMessage();
    `CHK("rollups", 1, rollups);
    avXfer(1'b0, OFS_CURSOR, 32'h00000000, rd);
    `CHK("cursor last", 32'h00001A00, rd);
    avXfer(1'b0, OFS_CHAR, 32'h00000000, rd);
    `CHK("return code", 32'h0000008D, rd);
    endOfTest();
  end
endmodule
